/* File: verilog/converter_firing_control_law.sv */
// Per-circuit control law: current loop, voltage path with clamps, per-unit scaling,
// rate and magnitude limiting, delay-angle limiting and antiparallel handling.
// Assumes measurements and external requests arrive synchronous to clk_i and are
// stable while a control step is being processed; registers over classic Wishbone.
//
// Functional notes
// - Current error is setpoint minus measured load current, every step.
// - Current-loop voltage is error times proportional gain plus integral term.
// - Integrate only while |error| below 2.5% of setpoint; otherwise clear integrator.
// - Command is voltage setpoint or external request; external only within plasma window.
// - In voltage mode, PI clamp acts outside clamp limits; integrator resets inside.
// - Voltage-loop request is selected command plus clamp voltage.
// - Near 98% of overcurrent, ceiling keeps predicted next current at or below 98%.
// - Elapsed pulse time picks voltage-loop or current-loop request.
// - Per-unit request is raw request over max no-load voltage from sections, line voltage.
// - Per-unit request saturates to minus one through plus one.
// - Programmable rate limit applies only while antiparallel mode holds.
// - Outside antiparallel, angle limited 0 to max delay from branch current, margin.
// - In antiparallel, minimum angle is 180 minus maximum; angle held between.
// - Switching amplifiers output the limited per-unit request as duty cycle.
// - First amplifier circuit's second slots carry DC source angle and convert bit.
// - In antiparallel, second converter fires at 180 minus first angle.
// - Antiparallel declared below threshold only after previous magnitude exceeded it.
// - Per-circuit enable permits or forbids antiparallel operation.
// - Selected circuits use total current halved in place of branch current.
// - Limited angles or duty and convert bits are delivered as control outputs.
//
// Local design decisions: the register addresses and register access over Wishbone.
`include "control_law_params.svh"
`timescale 1ns/1ps
`default_nettype none
module converter_firing_control_law (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire control_law_pkg::wb_req_s  wb_req_i,
   output var  control_law_pkg::wb_rsp_s  wb_rsp_o,
   input  wire control_law_pkg::meas_t    load_current_i,
   input  wire control_law_pkg::meas_t    external_voltage_request_i,
   output var  control_law_pkg::angle_t   first_angle_o,
   output var  control_law_pkg::angle_t   second_angle_o,
   output var  control_law_pkg::flag_t    convert_o,
   output var  control_law_pkg::flag_t    second_convert_flag_o,
   output var  control_law_pkg::flag_t    antiparallel_o,
   output var  logic                      step_done_o
);

   control_law_pkg::law_state_s st_reg;
   control_law_pkg::law_state_s st_next;

   function automatic logic signed [63:0] lim(input logic signed [63:0] v,
                                              input logic signed [63:0] lo,
                                              input logic signed [63:0] hi);
      lim = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : lim

   function automatic logic signed [63:0] sat24(input logic signed [63:0] v);
      sat24 = lim(v, `SAT24_MIN, `SAT24_MAX);
   endfunction : sat24

   function automatic logic signed [63:0] sx24(input logic [23:0] v);
      sx24 = 64'(signed'(v));
   endfunction : sx24

   function automatic logic signed [63:0] sx16(input logic [15:0] v);
      sx16 = 64'(signed'(v));
   endfunction : sx16

   function automatic logic signed [63:0] absv(input logic signed [63:0] v);
      absv = (v < 0) ? -v : v;
   endfunction : absv

   // Q16 reciprocal of a small count; a zero count behaves as one
   function automatic logic signed [63:0] recip16(input logic [3:0] n);
      logic [16:0] r;
      r = 17'h1_0000;
      if (n != 4'h0) begin
         r = 17'h1_0000 / {13'h0000, n};
      end
      recip16 = 64'(r);
   endfunction : recip16

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[8*b +: 8] = wd[8*b +: 8];
         end
      end
      merge = m;
   endfunction : merge

   always_comb begin
      logic        tick;
      logic [1:0]  ci;
      logic [3:0]  wi;
      logic [31:0] cc;
      logic [15:0] t;
      logic        vmode;
      logic        ext_ok;
      logic        ap_now;
      logic        first_amp;
      logic signed [63:0] i_ld, sp, err, integ_n, v_cur, vcmd, ce, cint_n, clamp_voltage, v_volt;
      logic signed [63:0] mag, oc, ceil, v0, pu, v1, v2, rate, isec, amax, amin, a0, a1, a2;
      tick = 1'b0;
      ci = st_reg.idx;
      wi = wb_req_i.adr[5:2];
      cc = st_reg.cfg[ci][`W_CTRL];
      t = st_reg.elapsed;
      vmode = 1'b0;
      ext_ok = 1'b0;
      ap_now = 1'b0;
      first_amp = 1'b0;
      i_ld = '0; sp = '0; err = '0; integ_n = '0; v_cur = '0; vcmd = '0; ce = '0;
      cint_n = '0; clamp_voltage = '0; v_volt = '0; mag = '0; oc = '0; ceil = '0; v0 = '0;
      pu = '0; v1 = '0; v2 = '0; rate = '0; isec = '0; amax = '0; amin = '0;
      a0 = '0; a1 = '0; a2 = '0;
      st_next = st_reg;
      st_next.done = 1'b0;

      // Step strobe divider; a period of zero behaves as one cycle
      if (st_reg.div_cnt + 32'h1 >= st_reg.step_period) begin
         tick = 1'b1;
         st_next.div_cnt = '0;
      end else begin
         st_next.div_cnt = st_reg.div_cnt + 32'h1;
      end

      case (st_reg.phase)
         control_law_pkg::LAW_IDLE: begin
            if (!st_reg.glob_ctrl[`F_RUN]) begin
               st_next.elapsed = '0;
            end else if (tick) begin
               st_next.phase = control_law_pkg::LAW_STEP;
               st_next.idx = '0;
               st_next.amp_seen = 1'b0;
            end
         end
         control_law_pkg::LAW_STEP: begin
            i_ld = sx24(load_current_i[ci]);
            sp = sx24(st_reg.cfg[ci][`W_CUR_SP][23:0]);
            mag = absv(i_ld);
            err = sat24(sp - i_ld);
            if (absv(err) * `ERR_WINDOW_RATIO < absv(sp)) begin
               integ_n = sat24(sx24(st_reg.integ[ci]) + err);
            end
            v_cur = sat24((err * sx16(st_reg.cfg[ci][`W_CUR_GAINS][15:0])
                         + integ_n * sx16(st_reg.cfg[ci][`W_CUR_GAINS][31:16])) >>> 8);

            vmode = (t >= st_reg.cfg[ci][`W_VMODE_WIN][15:0]) && (t < st_reg.cfg[ci][`W_VMODE_WIN][31:16]);
            ext_ok = cc[`F_EXT_SELECT] && (t >= st_reg.plasma_win[15:0]) && (t < st_reg.plasma_win[31:16]);
            vcmd = ext_ok ? sx24(external_voltage_request_i[ci])
                          : sx24(st_reg.cfg[ci][`W_VOLT_SP][23:0]);

            // Clamp integrator is also cleared outside voltage mode so it starts clean
            if (vmode && i_ld > sx24(st_reg.cfg[ci][`W_CLAMP_POS][23:0])) begin
               ce = sx24(st_reg.cfg[ci][`W_CLAMP_POS][23:0]) - i_ld;
            end else if (vmode && i_ld < sx24(st_reg.cfg[ci][`W_CLAMP_NEG][23:0])) begin
               ce = sx24(st_reg.cfg[ci][`W_CLAMP_NEG][23:0]) - i_ld;
            end
            if (ce != 0) begin
               cint_n = sat24(sx24(st_reg.clamp_integ[ci]) + ce);
               clamp_voltage = sat24((ce * sx16(st_reg.cfg[ci][`W_CLAMP_GAINS][15:0])
                             + cint_n * sx16(st_reg.cfg[ci][`W_CLAMP_GAINS][31:16])) >>> 8);
            end
            v_volt = sat24(vcmd + clamp_voltage);

            oc = sx24(st_reg.cfg[ci][`W_OVERCURRENT][23:0]);
            if (vmode && mag * `OC_NEAR_DEN >= oc * `OC_NEAR_NUM) begin
               // Ceiling = gain * (0.98 Overcurrent_setting - decay * |I|); gain and decay hold R and exp(-dt/tau)
               ceil = (oc * `OC_TARGET_PCT) / `PCT_DEN
                    - ((mag * $signed(64'(st_reg.cfg[ci][`W_PREDICT][15:0]))) >>> 16);
               ceil = sat24(lim((ceil * sx16(st_reg.cfg[ci][`W_PREDICT][31:16])) >>> 8, '0, `SAT24_MAX));
               v_volt = (i_ld >= 0) ? lim(v_volt, `SAT24_MIN, ceil)
                                    : lim(v_volt, -ceil, `SAT24_MAX);
            end

            v0 = vmode ? v_volt : v_cur;
            // Reciprocal kept signed so a negative request stays negative through the shifts
            pu = ((v0 * $signed(64'(st_reg.line_recip))) >>> 16) * recip16(cc[`F_NS_LSB +: 4]) >>> 16;
            v1 = lim(pu, -`PU_ONE, `PU_ONE);

            ap_now = cc[`F_AP_ENABLE] && !cc[`F_SW_AMP]
                  && (mag < sx24(st_reg.cfg[ci][`W_AP_THRESH][23:0]))
                  && (st_reg.ap[ci] || sx24(st_reg.prev_mag[ci]) > sx24(st_reg.cfg[ci][`W_AP_THRESH][23:0]));
            rate = 64'(st_reg.cfg[ci][`W_RATE_LIMIT][15:0]);
            v2 = ap_now ? lim(v1, sx16(st_reg.v2_prev[ci]) - rate, sx16(st_reg.v2_prev[ci]) + rate) : v1;

            isec = cc[`F_USE_TOTAL] ? (i_ld >>> 1)
                                    : ((i_ld * recip16(cc[`F_NP_LSB +: 4])) >>> 16);
            amax = `DEG180 - 64'(st_reg.cfg[ci][`W_ALPHA_LIM][15:0])
                 - ((absv(isec) * 64'(st_reg.cfg[ci][`W_ALPHA_LIM][31:16])) >>> 16);
            amax = lim(amax, '0, `DEG180);
            a0 = `DEG90 - ((v2 * `DEG90) >>> 14);
            if (ap_now) begin
               amin = `DEG180 - amax;
               a1 = (a0 > amax) ? amax : ((a0 < amin) ? amin : a0);
               a2 = `DEG180 - a1;
            end else begin
               a1 = lim(a0, '0, amax);
               a2 = a1;
            end

            first_amp = cc[`F_SW_AMP] && !st_reg.amp_seen;
            if (cc[`F_SW_AMP]) begin
               st_next.amp_seen = 1'b1;
               st_next.a1[ci] = v2[15:0];
               st_next.a2[ci] = first_amp ? st_reg.dc_angle[15:0] : 16'h0000;
               st_next.cv1[ci] = cc[`F_ENABLE];
               st_next.cv2[ci] = first_amp && st_reg.glob_ctrl[`F_DC_CONVERT];
            end else begin
               st_next.a1[ci] = a1[15:0];
               st_next.a2[ci] = a2[15:0];
               st_next.cv1[ci] = cc[`F_ENABLE] && (ap_now || !cc[`F_AP_ENABLE] || i_ld >= 0);
               st_next.cv2[ci] = cc[`F_ENABLE] && cc[`F_AP_ENABLE] && (ap_now || i_ld < 0);
            end
            st_next.integ[ci] = integ_n[23:0];
            st_next.clamp_integ[ci] = cint_n[23:0];
            st_next.prev_mag[ci] = 24'(sat24(mag));
            st_next.v2_prev[ci] = v2[15:0];
            st_next.ap[ci] = ap_now;
            if (ci == 2'(`NUM_CIRCUITS - 1)) begin
               st_next.phase = control_law_pkg::LAW_IDLE;
               st_next.done = 1'b1;
               if (st_reg.elapsed != 16'hffff) begin
                  st_next.elapsed = st_reg.elapsed + 16'h0001;
               end
            end else begin
               st_next.idx = ci + 2'h1;
            end
         end
         default: begin
            st_next.phase = control_law_pkg::LAW_IDLE;
         end
      endcase

      // Wishbone slave: answer one cycle after the strobe, drop ack the cycle after
      st_next.ack = wb_req_i.cyc && wb_req_i.stb && !st_reg.ack;
      st_next.rdat = '0;
      if (wb_req_i.cyc && wb_req_i.stb && !st_reg.ack) begin
         if (wb_req_i.adr[11:8] == 4'h0) begin
            case (wb_req_i.adr)
               `OFF_GLOBAL_CTRL:     st_next.rdat = {30'h0, st_reg.glob_ctrl[1:0]};
               `OFF_STEP_PERIOD:     st_next.rdat = st_reg.step_period;
               `OFF_PLASMA_WINDOW:   st_next.rdat = st_reg.plasma_win;
               `OFF_DC_SOURCE_ANGLE: st_next.rdat = {16'h0, st_reg.dc_angle[15:0]};
               `OFF_LINE_RECIP:      st_next.rdat = st_reg.line_recip;
               `OFF_STATUS:          st_next.rdat = {12'h0, st_reg.ap, st_reg.elapsed};
               default:              st_next.rdat = '0;
            endcase
            if (wb_req_i.we) begin
               case (wb_req_i.adr)
                  `OFF_GLOBAL_CTRL:     st_next.glob_ctrl = merge(st_reg.glob_ctrl, wb_req_i.dat, wb_req_i.sel);
                  `OFF_STEP_PERIOD:     st_next.step_period = merge(st_reg.step_period, wb_req_i.dat, wb_req_i.sel);
                  `OFF_PLASMA_WINDOW:   st_next.plasma_win = merge(st_reg.plasma_win, wb_req_i.dat, wb_req_i.sel);
                  `OFF_DC_SOURCE_ANGLE: st_next.dc_angle = merge(st_reg.dc_angle, wb_req_i.dat, wb_req_i.sel);
                  `OFF_LINE_RECIP:      st_next.line_recip = merge(st_reg.line_recip, wb_req_i.dat, wb_req_i.sel);
                  default:              st_next.rdat = st_next.rdat;
               endcase
            end
         end else if (wb_req_i.adr[11:8] == `CKT_PAGE) begin
            case (wi)
               `W_ANGLES: st_next.rdat = {st_reg.a2[wb_req_i.adr[7:6]], st_reg.a1[wb_req_i.adr[7:6]]};
               `W_FLAGS:  st_next.rdat = {29'h0, st_reg.cv2[wb_req_i.adr[7:6]],
                                          st_reg.cv1[wb_req_i.adr[7:6]], st_reg.ap[wb_req_i.adr[7:6]]};
               4'hf:      st_next.rdat = '0;
               default:   st_next.rdat = st_reg.cfg[wb_req_i.adr[7:6]][wi];
            endcase
            // Status words are read only; writes to them are dropped
            if (wb_req_i.we && wi < `W_ANGLES) begin
               st_next.cfg[wb_req_i.adr[7:6]][wi] = merge(st_reg.cfg[wb_req_i.adr[7:6]][wi],
                                                         wb_req_i.dat, wb_req_i.sel);
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.phase <= control_law_pkg::LAW_IDLE;
         st_reg.glob_ctrl <= `GLOBAL_CTRL_RST;
         st_reg.step_period <= `STEP_PERIOD_RST;
         st_reg.line_recip <= `LINE_RECIP_RST;
         for (int c = 0; c < `NUM_CIRCUITS; c++) begin
            st_reg.cfg[c][`W_CTRL] <= `CKT_CTRL_RST;
         end
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_rsp_o              = '{ack: st_reg.ack, dat: st_reg.rdat};
   assign first_angle_o         = st_reg.a1;
   assign second_angle_o        = st_reg.a2;
   assign convert_o             = st_reg.cv1;
   assign second_convert_flag_o = st_reg.cv2;
   assign antiparallel_o        = st_reg.ap;
   assign step_done_o           = st_reg.done;

endmodule : converter_firing_control_law
`default_nettype wire

/* File: verilog/control_law_params.svh */
// Constants of the converter firing control law: register offsets, field positions,
// reset values and fixed-point figures.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CONTROL_LAW_PARAMS_SVH
`define CONTROL_LAW_PARAMS_SVH
`define NUM_CIRCUITS        4
// Global registers, byte addresses
`define OFF_GLOBAL_CTRL     12'h000
`define OFF_STEP_PERIOD     12'h004
`define OFF_PLASMA_WINDOW   12'h008
`define OFF_DC_SOURCE_ANGLE 12'h00c
`define OFF_LINE_RECIP      12'h010
`define OFF_STATUS          12'h014
// Circuit n occupies 0x100 + 0x40*n, one word per index below
`define CKT_PAGE            4'h1
`define W_CTRL              4'h0
`define W_CUR_SP            4'h1
`define W_VOLT_SP           4'h2
`define W_CUR_GAINS         4'h3
`define W_CLAMP_GAINS       4'h4
`define W_CLAMP_POS         4'h5
`define W_CLAMP_NEG         4'h6
`define W_OVERCURRENT       4'h7
`define W_PREDICT           4'h8
`define W_VMODE_WIN         4'h9
`define W_RATE_LIMIT        4'ha
`define W_AP_THRESH         4'hb
`define W_ALPHA_LIM         4'hc
`define W_ANGLES            4'hd
`define W_FLAGS             4'he
// Field positions
`define F_RUN               0
`define F_DC_CONVERT        1
`define F_ENABLE            0
`define F_AP_ENABLE         1
`define F_SW_AMP            2
`define F_EXT_SELECT        3
`define F_USE_TOTAL         4
`define F_NS_LSB            8
`define F_NP_LSB            12
// Reset values
`define GLOBAL_CTRL_RST     32'h0000_0000
`define STEP_PERIOD_RST     32'h0000_09c4
`define LINE_RECIP_RST      32'h0001_0000
`define CKT_CTRL_RST        32'h0000_1100
// Fixed point: per unit Q14, angles Q7 degrees, gains Q8.8
`define PU_ONE              64'sh0000_0000_0000_4000
`define DEG90               64'sh0000_0000_0000_2d00
`define DEG180              64'sh0000_0000_0000_5a00
`define ERR_WINDOW_RATIO    64'sh0000_0000_0000_0028
`define OC_NEAR_NUM         64'sh0000_0000_0000_0031
`define OC_NEAR_DEN         64'sh0000_0000_0000_0032
`define OC_TARGET_PCT       64'sh0000_0000_0000_0062
`define PCT_DEN             64'sh0000_0000_0000_0064
`define SAT24_MAX           64'sh0000_0000_007f_ffff
`define SAT24_MIN           64'shffff_ffff_ff80_0000
`endif

/* File: verilog/control_law_pkg.sv */
// Types of the converter firing control law.
// Assumes the parameter header sits on the include path.
`include "control_law_params.svh"
`default_nettype none
package control_law_pkg;
   typedef enum logic {LAW_IDLE, LAW_STEP} law_phase_e;
   typedef logic [`NUM_CIRCUITS-1:0][23:0] meas_t;
   typedef logic [`NUM_CIRCUITS-1:0][15:0] angle_t;
   typedef logic [`NUM_CIRCUITS-1:0]       flag_t;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [11:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_s;
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_s;
   typedef struct packed {
      law_phase_e                             phase;
      logic [1:0]                             idx;
      logic [31:0]                            div_cnt;
      logic [15:0]                            elapsed;
      logic                                   amp_seen;
      logic [31:0]                            glob_ctrl;
      logic [31:0]                            step_period;
      logic [31:0]                            plasma_win;
      logic [31:0]                            dc_angle;
      logic [31:0]                            line_recip;
      logic [`NUM_CIRCUITS-1:0][15:0][31:0]   cfg;
      logic [`NUM_CIRCUITS-1:0][23:0]         integ;
      logic [`NUM_CIRCUITS-1:0][23:0]         clamp_integ;
      logic [`NUM_CIRCUITS-1:0][23:0]         prev_mag;
      logic [`NUM_CIRCUITS-1:0][15:0]         v2_prev;
      flag_t                                  ap;
      angle_t                                 a1;
      angle_t                                 a2;
      flag_t                                  cv1;
      flag_t                                  cv2;
      logic                                   done;
      logic                                   ack;
      logic [31:0]                            rdat;
   } law_state_s;
endpackage : control_law_pkg
`default_nettype wire

/* File: dv/converter_firing_control_law_properties.sv */
// Checker for the firing control law: bus handshake, step timing, antiparallel mirror.
// Sees only the top module's ports and is bound to it below.
`timescale 1ns/1ps
`default_nettype none
module converter_firing_control_law_properties (
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   input wire control_law_pkg::wb_req_s wb_req_i,
   input wire control_law_pkg::wb_rsp_s wb_rsp_o,
   input wire control_law_pkg::angle_t  first_angle_o,
   input wire control_law_pkg::angle_t  second_angle_o,
   input wire control_law_pkg::flag_t   antiparallel_o,
   input wire logic                    step_done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence bus_req;
      wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
   endsequence
   sequence ack_pulse;
      wb_rsp_o.ack ##1 !wb_rsp_o.ack;
   endsequence
   a_bus_answer: assert property (bus_req |=> ack_pulse) else $error("bus request without one-cycle ack");
   a_ack_cause: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb)) else $error("ack with no request");
   a_idle_data: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == '0) else $error("read data outside ack");
   a_done_spacing: assert property (step_done_o |=> !step_done_o [*4]) else $error("step done too close");
   a_ckt_order: assert property ($changed(first_angle_o[0]) |-> ##3 step_done_o) else $error("circuit 0 out of turn");
   a_last_ckt: assert property ($changed(first_angle_o[3]) |-> step_done_o) else $error("circuit 3 out of turn");
   a_reset_quiet: assert property ($fell(rst_i) |-> first_angle_o == '0 && antiparallel_o == '0 && !step_done_o)
      else $error("outputs not clear after reset");
   for (genvar i = 0; i < 4; i++) begin : g_ap
      a_ap_mirror: assert property (antiparallel_o[i] |-> second_angle_o[i] == 16'(16'h5a00 - first_angle_o[i]))
         else $error("second converter not mirrored");
   end
endmodule : converter_firing_control_law_properties
bind converter_firing_control_law converter_firing_control_law_properties u_props (.clk_i, .rst_i, .wb_req_i,
   .wb_rsp_o, .first_angle_o, .second_angle_o, .antiparallel_o, .step_done_o);
`default_nettype wire

/* File: dv/rectifier_load_model.sv */
// Far side model: load current and external voltage request per circuit.
// New values land only at a step boundary, so every circuit of a step sees one sample.
`timescale 1ns/1ps
`default_nettype none
module rectifier_load_model (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  step_done_i,
   input  wire control_law_pkg::meas_t current_target_i,
   input  wire control_law_pkg::meas_t request_target_i,
   output var  control_law_pkg::meas_t load_current_o,
   output var  control_law_pkg::meas_t external_voltage_request_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_current_o             <= '0;
         external_voltage_request_o <= '0;
      end else if (step_done_i) begin
         load_current_o             <= current_target_i;
         external_voltage_request_o <= request_target_i;
      end
   end
endmodule : rectifier_load_model
`default_nettype wire

/* File: dv/converter_firing_control_law_test.sv */
// Self-checking bench: registers over Wishbone, duty path, slot reuse, antiparallel flag.
// Assumes the design package and the load model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module converter_firing_control_law_test;
   logic                     clk_i = 1'b0;
   logic                     rst_i = 1'b1;
   control_law_pkg::wb_req_s wb_req_i = '0;
   control_law_pkg::wb_rsp_s wb_rsp_o;
   control_law_pkg::meas_t   load_current_i, external_voltage_request_i, cur_tgt = '0, req_tgt = '0;
   control_law_pkg::angle_t  first_angle_o, second_angle_o;
   control_law_pkg::flag_t   convert_o, second_convert_flag_o, antiparallel_o;
   logic                     step_done_o;
   int                       num_errors = 0;
   int                       n_tests = 0;
   logic [31:0]              rd, vsp, dc, e;
   logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h010, 12'h100, 12'h1c0, 12'h020};
   logic [31:0] rv [6] = '{32'h0, 32'h9c4, 32'h10000, 32'h1100, 32'h1100, 32'h0};
   logic [11:0] ca [14] = '{12'h004, 12'h008, 12'h100, 12'h124, 12'h11c, 12'h140, 12'h164, 12'h15c, 12'h148,
                            12'h180, 12'h1ac, 12'h1c0, 12'h1ec, 12'h000};
   logic [31:0] cv [14] = '{32'h8, 32'hffff0000, 32'h1105, 32'hffff0000, 32'h7fffff, 32'h110d, 32'hffff0000,
                            32'h7fffff, 32'h123, 32'h1103, 32'h100, 32'h1101, 32'h100, 32'h3};
   always #2 clk_i = ~clk_i;
   converter_firing_control_law u_converter_firing_control_law (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o,
      .load_current_i, .external_voltage_request_i, .first_angle_o, .second_angle_o, .convert_o,
      .second_convert_flag_o, .antiparallel_o, .step_done_o);
   rectifier_load_model u_rectifier_load_model (.clk_i, .rst_i, .step_done_i(step_done_o),
      .current_target_i(cur_tgt), .request_target_i(req_tgt), .load_current_o(load_current_i),
      .external_voltage_request_o(external_voltage_request_i));
   task automatic end_sim();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
      // Ack is watched mid-cycle where it is settled; the request drops at the edge that samples it
      do begin
         @(negedge clk_i);
         n++;
      end while (wb_rsp_o.ack !== 1'b1 && n < 50);
      rd = wb_rsp_o.dat;
      @(posedge clk_i);
      wb_req_i <= '0;
      @(posedge clk_i);
      if (n >= 50) begin
         num_errors++;
         end_sim();
      end
   endtask : wb
   // Waits for k completed control steps
   task automatic steps(input int k);
      int n;
      repeat (k) begin
         n = 0;
         do begin
            @(negedge clk_i);
            n++;
         end while (step_done_o !== 1'b1 && n < 100);
         @(posedge clk_i);
         if (n >= 100) begin
            num_errors++;
            end_sim();
         end
      end
   endtask : steps
   // Per-unit duty with a unit line reciprocal and one series section, saturated to one
   function automatic logic [15:0] duty(input logic signed [31:0] v);
      if (v > 32'sh4000) return 16'h4000;
      if (v < -32'sh4000) return 16'hc000;
      return v[15:0];
   endfunction : duty
   initial begin
      rd = $urandom(58);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b1, 12'h020, 32'hffffffff);
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, ra[i], 32'h0);
         check(rd, rv[i]);
      end
      for (int i = 0; i < 14; i++) wb(1'b1, ca[i], cv[i]);
      for (int k = 0; k < 8; k++) begin
         vsp = k == 0 ? 32'h007fffff : k == 1 ? 32'hff800000 : $urandom_range(32'hc000) - 32'h6000;
         e = $urandom_range(32'hc000) - 32'h6000;
         dc = $urandom_range(32'h5a00);
         req_tgt[1] <= e[23:0];
         wb(1'b1, 12'h108, vsp);
         wb(1'b1, 12'h00c, dc);
         steps(2);
         check(first_angle_o[0], duty(vsp));
         check(first_angle_o[1], duty(e));
         check({second_convert_flag_o[0], second_angle_o[0]}, {1'b1, dc[15:0]});
         check({second_convert_flag_o[1], second_angle_o[1]}, 32'h0);
         wb(1'b0, 12'h134, 32'h0);
         check(rd, {dc[15:0], duty(vsp)});
      end
      wb(1'b1, 12'h008, 32'h0);
      steps(2);
      check(first_angle_o[1], 32'h123);
      check(antiparallel_o[3:2], 32'h0);
      cur_tgt[2] <= 24'h1000;
      cur_tgt[3] <= 24'h1000;
      steps(2);
      cur_tgt[2] <= 24'h10;
      cur_tgt[3] <= 24'h10;
      steps(2);
      check(antiparallel_o[3:2], 32'h1);
      check({convert_o, second_convert_flag_o}, 32'hf5);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({antiparallel_o, step_done_o, first_angle_o[0]}, 32'h0);
      end_sim();
   end
endmodule : converter_firing_control_law_test
`default_nettype wire
